// *** logic/usb_host_pipe_control.v ***
`include "usb_pipe_map.vh"
`default_nettype none

// Summary of operation
// - a write to a pipe's clear alias clears each control bit in CTRL_CLR_MASK written as one, leaves the rest, and reads zero.
// - a write to a pipe's set alias sets each control bit in CTRL_SET_MASK written as one, leaves the rest, and reads zero.
// - set strobes cover toggle reinit, halt and dma block; clear strobes cover halt, dma block and bank handover.
// - with endless request mode set the pipe requests for as long as it is not halted, ignoring the count.
// - with endless request mode clear the pipe makes request_count plus one IN requests and then halts.
// - outside endless request mode each successful IN request decrements a nonzero 8-bit request count by one.
// - a two-bit error counter increments on any of the five errors and clears on an error-free packet.
// - when the error counter reaches three the pipe halt bit is set.
// - software writing zero to the error counter field clears it.
// - each error flag is set by hardware when its error is detected.
// - writing zero to an error flag clears it and writing one leaves it unchanged.
// - while the halt bit is set the pipe makes no requests, and clearing it re-enables them.
// - setting toggle reinit returns the data toggle to its start value and the bit then clears itself.
// - clearing bank handover sends or frees the current bank and moves to the next one.
module usb_host_pipe_control #(
  parameter NP = `NUM_PIPES,
  parameter AW = 12
) (
  input wire ref_clk, // 20 MHz system clock
  input wire arst_n, // asynchronous reset, active low
  input wire [AW-1:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response code
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [AW-1:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response code
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire [2:0] txn_pipe, // pipe that the transaction event belongs to
  input wire txn_in_ok, // pulse: IN request finished without error
  input wire txn_err_valid, // pulse: txn_err holds detected errors
  input wire [4:0] txn_err, // crc16, timeout, pid, data pid, toggle
  input wire txn_good, // pulse: packet received with no error
  input wire [NP-1:0] bank_ready, // pulse per pipe: current bank free or filled
  input wire [NP-1:0] halt_req, // pulse per pipe: stall, reset or other halt cause
  output wire [NP-1:0] pipe_halt, // pipe may not issue requests
  output wire [NP-1:0] endless_request_mode, // pipe requests until halted
  output wire [NP-1:0] toggle_reinit, // one-cycle pulse: reset data toggle
  output reg [NP-1:0] bank_release, // one-cycle pulse: send or free bank
  output wire [NP-1:0] dma_block, // pipe interrupts block dma requests
  output wire [NP*9-1:0] irq_enables, // per pipe: busy bank enable, 8 enables
  output wire irq // level interrupt
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  reg rst_meta;
  reg rst_n;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // {hit, index} for a seven-word window starting at base
  function [3:0] pipe_slot;
    input [AW-1:0] a;
    input [AW-1:0] base;
    reg [AW-1:0] off;
    begin
      off = a - base;
      pipe_slot = {(a >= base) && (off[1:0] == 2'h0) && (off[AW-1:2] < NP), off[4:2]};
    end
  endfunction

  function [31:0] byte_mask;
    input [3:0] s;
    begin
      byte_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  reg aw_held;
  reg w_held;
  reg [AW-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  // a new write waits until the previous response is taken, so at most one is in flight
  wire wr_go = aw_held && w_held && !s_axi_bvalid;
  wire [31:0] bmask = byte_mask(w_strb);
  wire [31:0] wd = w_data & bmask;
  wire [3:0] wr_set = pipe_slot(aw_addr, `PIPE_CONTROL_SET_ALIAS);
  wire [3:0] wr_clr = pipe_slot(aw_addr, `PIPE_CONTROL_CLEAR_ALIAS);
  wire [3:0] wr_request_count = pipe_slot(aw_addr, `PIPE_IN_REQUEST_COUNT);
  wire [3:0] wr_err = pipe_slot(aw_addr, `PIPE_ERROR_FLAGS);
  wire [3:0] wr_ctl = pipe_slot(aw_addr, `PIPE_CONTROL_REG);
  wire wr_iclr = aw_addr == `PIPE_IRQ_CLEAR;
  wire wr_ien = aw_addr == `PIPE_IRQ_ENABLE;
  wire wr_istat = aw_addr == `PIPE_IRQ_STATUS;
  wire wr_mapped = wr_set[3] | wr_clr[3] | wr_request_count[3] | wr_err[3] | wr_ctl[3] | wr_iclr | wr_ien | wr_istat;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;

  // address and data are taken in either order and held until both are here
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {AW{1'b0}};
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // per pipe state
  // ----------------------------------------
  wire [31:0] ctrl_rd [0:NP-1];
  wire [31:0] request_count_rd [0:NP-1];
  wire [31:0] err_rd [0:NP-1];
  wire [NP-1:0] err_limit_ev;
  wire [NP-1:0] count_done_ev;
  wire [NP-1:0] bank_rel_next;

  genvar i;
  generate
    for (i = 0; i < NP; i = i + 1) begin : pipe
      reg [`CTRL_W-1:0] ctrl;
      reg [`REQUEST_COUNT_W-1:0] request_count;
      reg [`ERR_W-1:0] err;
      reg [`CTRL_W-1:0] next_ctrl;
      reg [`REQUEST_COUNT_W-1:0] next_request_count;
      reg [`ERR_W-1:0] next_err;
      reg lim;
      reg done;
      wire mine = txn_pipe == i;
      wire ev_ok = txn_in_ok && mine;
      // an error event with no kind flagged counts as no event at all
      wire ev_err = txn_err_valid && mine && (txn_err != 5'h00);
      wire ev_good = txn_good && mine;
      wire set_hit = wr_go && wr_set[3] && (wr_set[2:0] == i);
      wire clr_hit = wr_go && wr_clr[3] && (wr_clr[2:0] == i);
      wire request_count_hit = wr_go && wr_request_count[3] && (wr_request_count[2:0] == i);
      wire err_hit = wr_go && wr_err[3] && (wr_err[2:0] == i);

      always @* begin
        next_request_count = request_count;
        done = 1'b0;
        if (request_count_hit) begin
          next_request_count = (request_count & ~bmask[`REQUEST_COUNT_W-1:0]) | wd[`REQUEST_COUNT_W-1:0];
        end
        // requests are only counted when not endless; the last one halts the pipe
        if (ev_ok && !request_count[`REQUEST_COUNT_MODE]) begin
          if (request_count[7:0] == 8'h00) begin
            done = 1'b1;
          end else begin
            next_request_count[7:0] = request_count[7:0] - 8'h01;
          end
        end

        next_err = err;
        if (err_hit) begin
          next_err[4:0] = err[4:0] & (w_data[4:0] | ~bmask[4:0]);
          if (w_strb[0] && (w_data[6:5] == 2'h0)) begin
            next_err[6:5] = 2'h0;
          end
        end
        lim = 1'b0;
        if (ev_err) begin
          next_err[4:0] = next_err[4:0] | txn_err;
          if (next_err[6:5] != `ERR_CNT_MAX) begin
            next_err[6:5] = next_err[6:5] + 2'h1;
          end
          lim = next_err[6:5] == `ERR_CNT_MAX;
        end else if (ev_good) begin
          next_err[6:5] = 2'h0;
        end

        next_ctrl = ctrl;
        // toggle reinit lives one cycle only: the toggle logic acts on the pulse
        next_ctrl[`CTRL_TOGGLE_REINIT] = 1'b0;
        if (set_hit) begin
          next_ctrl = next_ctrl | (wd[`CTRL_W-1:0] & `CTRL_SET_MASK);
        end
        if (clr_hit) begin
          next_ctrl = next_ctrl & ~(wd[`CTRL_W-1:0] & `CTRL_CLR_MASK);
        end
        // hardware sets win over a clear strobe in the same cycle
        if (done || lim || halt_req[i]) begin
          next_ctrl[`CTRL_HALT] = 1'b1;
        end
        if (bank_ready[i]) begin
          next_ctrl[`CTRL_BANK_HANDOVER] = 1'b1;
        end
      end

      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          ctrl <= `CTRL_RESET;
          request_count <= `REQUEST_COUNT_RESET;
          err <= `ERR_RESET;
        end else begin
          ctrl <= next_ctrl;
          request_count <= next_request_count;
          err <= next_err;
        end
      end

      assign ctrl_rd[i] = {{(32-`CTRL_W){1'b0}}, ctrl};
      assign request_count_rd[i] = {{(32-`REQUEST_COUNT_W){1'b0}}, request_count};
      assign err_rd[i] = {{(32-`ERR_W){1'b0}}, err};
      assign err_limit_ev[i] = lim;
      assign count_done_ev[i] = done;
      assign bank_rel_next[i] = clr_hit && wd[`CTRL_BANK_HANDOVER] && ctrl[`CTRL_BANK_HANDOVER];
      assign pipe_halt[i] = ctrl[`CTRL_HALT];
      assign endless_request_mode[i] = request_count[`REQUEST_COUNT_MODE];
      assign toggle_reinit[i] = ctrl[`CTRL_TOGGLE_REINIT];
      assign dma_block[i] = ctrl[`CTRL_DMA_BLOCK];
      assign irq_enables[i*9 +: 9] = {ctrl[12], ctrl[7:0]};
    end
  endgenerate

  // one register for every pipe keeps a single driver on the pulse output
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_release <= {NP{1'b0}};
    end else begin
      bank_release <= bank_rel_next;
    end
  end

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  reg [`IRQ_W-1:0] irq_status;
  reg [`IRQ_W-1:0] irq_enable;
  wire [`IRQ_W-1:0] irq_events = {count_done_ev, err_limit_ev};
  wire iclr_hit = wr_go && wr_iclr;
  wire ien_hit = wr_go && wr_ien;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= {`IRQ_W{1'b0}};
      irq_enable <= {`IRQ_W{1'b0}};
    end else begin
      // an event in the clearing cycle survives the clear
      irq_status <= (irq_status & ~(iclr_hit ? wd[`IRQ_W-1:0] : {`IRQ_W{1'b0}})) | irq_events;
      if (ien_hit) begin
        irq_enable <= (irq_enable & ~bmask[`IRQ_W-1:0]) | wd[`IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_enable);

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  wire [3:0] rd_ctl = pipe_slot(s_axi_araddr, `PIPE_CONTROL_REG);
  wire [3:0] rd_set = pipe_slot(s_axi_araddr, `PIPE_CONTROL_SET_ALIAS);
  wire [3:0] rd_clr = pipe_slot(s_axi_araddr, `PIPE_CONTROL_CLEAR_ALIAS);
  wire [3:0] rd_request_count = pipe_slot(s_axi_araddr, `PIPE_IN_REQUEST_COUNT);
  wire [3:0] rd_err = pipe_slot(s_axi_araddr, `PIPE_ERROR_FLAGS);
  reg [31:0] rd_value;
  reg rd_ok;

  // the answer is captured when the address is taken, so later state changes do not alter it
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    rd_value = 32'h00000000;
    rd_ok = 1'b1;
    if (rd_ctl[3]) begin
      rd_value = ctrl_rd[rd_ctl[2:0]];
    end else if (rd_request_count[3]) begin
      rd_value = request_count_rd[rd_request_count[2:0]];
    end else if (rd_err[3]) begin
      rd_value = err_rd[rd_err[2:0]];
    end else if (s_axi_araddr == `PIPE_IRQ_STATUS) begin
      rd_value = {{(32-`IRQ_W){1'b0}}, irq_status};
    end else if (s_axi_araddr == `PIPE_IRQ_ENABLE) begin
      rd_value = {{(32-`IRQ_W){1'b0}}, irq_enable};
    end else if (rd_set[3] || rd_clr[3] || s_axi_araddr == `PIPE_IRQ_CLEAR) begin
      rd_value = 32'h00000000;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** pkg/usb_pipe_map.vh ***
`ifndef USB_PIPE_MAP_VH
`define USB_PIPE_MAP_VH

// ----------------------------------------
// pipe register windows, byte addresses
// ----------------------------------------
`define NUM_PIPES 7
`define PIPE_STRIDE 12'h004
`define PIPE_CONTROL_REG 12'h5c0
`define PIPE_CONTROL_SET_ALIAS 12'h5f0
`define PIPE_CONTROL_CLEAR_ALIAS 12'h620
`define PIPE_IN_REQUEST_COUNT 12'h650
`define PIPE_ERROR_FLAGS 12'h680
`define PIPE_IRQ_STATUS 12'h6b0
`define PIPE_IRQ_CLEAR 12'h6b4
`define PIPE_IRQ_ENABLE 12'h6b8

// ----------------------------------------
// pipe control fields
// ----------------------------------------
`define CTRL_W 19
`define CTRL_TOGGLE_REINIT 18
`define CTRL_HALT 17
`define CTRL_DMA_BLOCK 16
`define CTRL_BANK_HANDOVER 14
`define CTRL_SET_MASK 19'h710ff
`define CTRL_CLR_MASK 19'h350ff
`define CTRL_RESET 19'h00000

// ----------------------------------------
// in request and error fields
// ----------------------------------------
`define REQUEST_COUNT_W 9
`define REQUEST_COUNT_MODE 8
`define REQUEST_COUNT_RESET 9'h000
`define ERR_W 7
`define ERR_CNT_LO 5
`define ERR_CNT_MAX 2'h3
`define ERR_RESET 7'h00

// ----------------------------------------
// interrupt status layout and bus answers
// ----------------------------------------
`define IRQ_W 14
`define IRQ_DONE_LO 7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** bench/usb_pipe_sva.sv ***
`default_nettype none
module usb_pipe_sva #(parameter NP = 7) (
  input wire ref_clk, // clock
  input wire arst_n, // reset
  input wire s_axi_awvalid, // aw valid
  input wire s_axi_awready, // aw ready
  input wire s_axi_wvalid, // w valid
  input wire s_axi_wready, // w ready
  input wire s_axi_bvalid, // b valid
  input wire s_axi_arvalid, // ar valid
  input wire s_axi_arready, // ar ready
  input wire s_axi_rvalid, // r valid
  input wire [2:0] txn_pipe, // event pipe
  input wire txn_in_ok, // ok event
  input wire txn_err_valid, // error event
  input wire [4:0] txn_err, // error kinds
  input wire [NP-1:0] halt_req, // halt causes
  input wire [NP-1:0] pipe_halt, // halt bits
  input wire [NP-1:0] endless_request_mode, // mode bits
  input wire [NP-1:0] toggle_reinit, // toggle pulses
  input wire [NP-1:0] bank_release // bank pulses
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // a held write could legally clear the counter, so only quiet bus cycles count
  sequence s_err0; txn_err_valid && txn_err != 5'h00 && txn_pipe == 3'h0 && s_axi_awready; endsequence
  property p_err_halt; s_err0 ##1 s_err0 ##1 s_err0 |=> pipe_halt[0]; endproperty
  a_err_halt: assert property (p_err_halt) else $error("pipe not halted after three errors");
  property p_halt_req; halt_req != '0 |=> (pipe_halt & $past(halt_req)) == $past(halt_req); endproperty
  a_halt_req: assert property (p_halt_req) else $error("halt cause did not halt pipe");
  property p_toggle; toggle_reinit != '0 |=> (toggle_reinit & $past(toggle_reinit)) == '0; endproperty
  a_toggle: assert property (p_toggle) else $error("toggle reinit not self clearing");
  property p_bank; bank_release != '0 |=> (bank_release & $past(bank_release)) == '0; endproperty
  a_bank: assert property (p_bank) else $error("bank release longer than one cycle");
  property p_endless;
    txn_in_ok && endless_request_mode[txn_pipe] && !pipe_halt[txn_pipe] && !txn_err_valid && halt_req == '0
      && s_axi_awready |=> !pipe_halt[$past(txn_pipe)];
  endproperty
  a_endless: assert property (p_endless) else $error("endless pipe halted on ok");
  property p_ar_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
  // the pair is held one cycle before the response register rises
  property p_b_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("write answer late");
  property p_ar_rdy; !s_axi_rvalid |-> s_axi_arready; endproperty
  a_ar_rdy: assert property (p_ar_rdy) else $error("read address refused while idle");
  c_err: cover property (s_err0 ##1 s_err0 ##1 s_err0);
  c_bank: cover property (bank_release != '0);
  c_toggle: cover property (toggle_reinit != '0);
endmodule
bind usb_host_pipe_control usb_pipe_sva #(.NP(NP)) u_sva (.ref_clk(ref_clk), .arst_n(arst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .txn_pipe(txn_pipe), .txn_in_ok(txn_in_ok),
  .txn_err_valid(txn_err_valid), .txn_err(txn_err), .halt_req(halt_req), .pipe_halt(pipe_halt),
  .endless_request_mode(endless_request_mode), .toggle_reinit(toggle_reinit), .bank_release(bank_release));
`default_nettype wire

// *** bench/usb_dev_model.sv ***
`default_nettype none
module usb_dev_model (
  input wire logic ref_clk, // clock
  output logic [2:0] txn_pipe, // event pipe
  output logic txn_in_ok, // ok pulse
  output logic txn_err_valid, // error pulse
  output logic [4:0] txn_err, // error kinds
  output logic txn_good, // good packet pulse
  output logic [6:0] bank_ready, // bank pulses
  output logic [6:0] halt_req // halt pulses
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // bus traffic
  // ----------------------------------------
  initial begin
    txn_pipe = 3'h0;
    txn_in_ok = 1'b0;
    txn_err_valid = 1'b0;
    txn_err = 5'h00;
    txn_good = 1'b0;
    bank_ready = 7'h00;
    halt_req = 7'h00;
  end
  task ev(input logic [2:0] p, input logic ok, input logic ev_err, input logic [4:0] er, input logic g, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      txn_pipe <= p;
      txn_in_ok <= ok;
      txn_err_valid <= ev_err;
      txn_err <= er;
      txn_good <= g;
    end
    @(posedge ref_clk);
    txn_in_ok <= 1'b0;
    txn_err_valid <= 1'b0;
    txn_good <= 1'b0;
    // pipe and error lines mean nothing between events, so they do not keep the old value
    txn_pipe <= ~p;
    txn_err <= ~er;
  endtask
  task pins(input logic [6:0] b, input logic [6:0] h);
    @(posedge ref_clk);
    bank_ready <= b;
    halt_req <= h;
    @(posedge ref_clk);
    bank_ready <= 7'h00;
    halt_req <= 7'h00;
  endtask
endmodule
`default_nettype wire

// *** bench/tb_usb_host_pipe_control.sv ***
`include "usb_pipe_map.vh"
`default_nettype none
module tb_usb_host_pipe_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, txn_in_ok, txn_err_valid, txn_good;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0] txn_pipe;
  wire [4:0] txn_err;
  wire [6:0] bank_ready, halt_req, pipe_halt, endless_request_mode, toggle_reinit, bank_release, dma_block;
  wire [62:0] irq_enables;
  int mismatches = 0;
  int cmp_count = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [6:0] toggle_seen = 7'h00, bank_seen = 7'h00;
  always #25 ref_clk = ~ref_clk;
  // one-cycle pulses are collected so that a later compare still sees them
  always @(posedge ref_clk) begin
    toggle_seen <= toggle_seen | toggle_reinit;
    bank_seen <= bank_seen | bank_release;
  end
  usb_host_pipe_control DUT (.ref_clk(ref_clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .txn_pipe(txn_pipe), .txn_in_ok(txn_in_ok), .txn_err_valid(txn_err_valid),
    .txn_err(txn_err), .txn_good(txn_good), .bank_ready(bank_ready), .halt_req(halt_req), .pipe_halt(pipe_halt),
    .endless_request_mode(endless_request_mode), .toggle_reinit(toggle_reinit), .bank_release(bank_release),
    .dma_block(dma_block), .irq_enables(irq_enables), .irq(irq));
  usb_dev_model dev (.ref_clk(ref_clk), .txn_pipe(txn_pipe), .txn_in_ok(txn_in_ok), .txn_err_valid(txn_err_valid),
    .txn_err(txn_err), .txn_good(txn_good), .bank_ready(bank_ready), .halt_req(halt_req));
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'b0;
    chk("bvalid", s_axi_bvalid, 1'b1);
    chk("bresp", s_axi_bresp, r);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'b0;
    chk("rvalid", s_axi_rvalid, 1'b1);
    chk("rdata", s_axi_rdata, e);
    chk("rresp", s_axi_rresp, r);
  endtask
  task settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_alias;
    wr(`PIPE_CONTROL_SET_ALIAS + 12'h00c, 32'h000710ff, `RESP_OKAY);
    rd(`PIPE_CONTROL_REG + 12'h00c, 32'h000310ff, `RESP_OKAY);
    settle;
    chk("halt", pipe_halt, 7'h08);
    chk("dma", dma_block, 7'h08);
    chk("enables", irq_enables[35:27], 9'h1ff);
    chk("toggle", toggle_seen, 7'h08);
    rd(`PIPE_CONTROL_REG, 32'h00000000, `RESP_OKAY);
    rd(`PIPE_CONTROL_SET_ALIAS + 12'h00c, 32'h00000000, `RESP_OKAY);
    wr(`PIPE_CONTROL_CLEAR_ALIAS + 12'h00c, 32'h00024001, `RESP_OKAY);
    rd(`PIPE_CONTROL_REG + 12'h00c, 32'h000110fe, `RESP_OKAY);
    rd(`PIPE_CONTROL_CLEAR_ALIAS + 12'h00c, 32'h00000000, `RESP_OKAY);
  endtask
  task t_count;
    wr(`PIPE_IN_REQUEST_COUNT + 12'h004, 32'h00000001, `RESP_OKAY);
    dev.ev(3'h1, 1'b1, 1'b0, 5'h00, 1'b0, 1);
    rd(`PIPE_IN_REQUEST_COUNT + 12'h004, 32'h00000000, `RESP_OKAY);
    chk("halt", pipe_halt[1], 1'b0);
    dev.ev(3'h1, 1'b1, 1'b0, 5'h00, 1'b0, 1);
    settle;
    chk("halt", pipe_halt[1], 1'b1);
    chk("irq", irq, 1'b0);
    wr(`PIPE_IRQ_ENABLE, 32'h00000100, `RESP_OKAY);
    settle;
    chk("irq", irq, 1'b1);
    wr(`PIPE_IRQ_CLEAR, 32'h00000100, `RESP_OKAY);
    settle;
    chk("irq", irq, 1'b0);
    wr(`PIPE_IN_REQUEST_COUNT + 12'h004, 32'h00000100, `RESP_OKAY);
    wr(`PIPE_CONTROL_CLEAR_ALIAS + 12'h004, 32'h00020000, `RESP_OKAY);
    dev.ev(3'h1, 1'b1, 1'b0, 5'h00, 1'b0, 3);
    settle;
    chk("halt", pipe_halt[1], 1'b0);
    chk("mode", endless_request_mode[1], 1'b1);
    rd(`PIPE_IN_REQUEST_COUNT + 12'h004, 32'h00000100, `RESP_OKAY);
  endtask
  task t_err;
    dev.ev(3'h0, 1'b0, 1'b1, 5'h10, 1'b0, 1);
    rd(`PIPE_ERROR_FLAGS, 32'h00000030, `RESP_OKAY);
    dev.ev(3'h0, 1'b0, 1'b0, 5'h00, 1'b1, 1);
    rd(`PIPE_ERROR_FLAGS, 32'h00000010, `RESP_OKAY);
    dev.ev(3'h0, 1'b0, 1'b1, 5'h0e, 1'b0, 3);
    rd(`PIPE_ERROR_FLAGS, 32'h0000007e, `RESP_OKAY);
    chk("halt", pipe_halt[0], 1'b1);
    rd(`PIPE_IRQ_STATUS, 32'h00000001, `RESP_OKAY);
    wr(`PIPE_ERROR_FLAGS, 32'h0000001f, `RESP_OKAY);
    rd(`PIPE_ERROR_FLAGS, 32'h0000001e, `RESP_OKAY);
    wr(`PIPE_ERROR_FLAGS, 32'h00000006, `RESP_OKAY);
    rd(`PIPE_ERROR_FLAGS, 32'h00000006, `RESP_OKAY);
    dev.ev(3'h0, 1'b0, 1'b1, 5'h01, 1'b0, 1);
    rd(`PIPE_ERROR_FLAGS, 32'h00000027, `RESP_OKAY);
    s_axi_wstrb <= 4'he;
    wr(`PIPE_ERROR_FLAGS, 32'h00000000, `RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(`PIPE_ERROR_FLAGS, 32'h00000027, `RESP_OKAY);
  endtask
  task t_bank;
    dev.pins(7'h20, 7'h40);
    rd(`PIPE_CONTROL_REG + 12'h014, 32'h00004000, `RESP_OKAY);
    chk("halt", pipe_halt[6], 1'b1);
    wr(`PIPE_CONTROL_CLEAR_ALIAS + 12'h014, 32'h00004000, `RESP_OKAY);
    rd(`PIPE_CONTROL_REG + 12'h014, 32'h00000000, `RESP_OKAY);
    chk("bank", bank_seen, 7'h20);
    wr(12'h700, 32'h0000ffff, `RESP_SLVERR);
    rd(12'h700, 32'h00000000, `RESP_SLVERR);
  endtask
  task t_reset;
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    settle;
    chk("halt", pipe_halt, 7'h00);
    rd(`PIPE_ERROR_FLAGS, 32'h00000000, `RESP_OKAY);
    rd(`PIPE_IRQ_ENABLE, 32'h00000000, `RESP_OKAY);
  endtask
  task close_out;
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_alias;
    t_count;
    t_err;
    t_bank;
    t_reset;
    close_out;
  end
  // the whole run needs well under two thousand cycles
  initial begin
    #200000;
    mismatches++;
    close_out;
  end
endmodule
`default_nettype wire
